// >>> swms_asserts.sv
`timescale 1ns/1ns
// Watches the register block from its ports only.
module swms_asserts
   import swms_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic timer_a_req_i,
   input wire logic sleep_exec_i,
   input wire logic direct_taken_i,
   input wire logic timer_a_irq_o,
   input wire logic direct_irq_o,
   input wire logic ext_edge_o,
   input wire logic trig_edge_o,
   input wire logic direct_transfer_on_o,
   input wire swms_pkg::swms_run_type run_o
);
   logic [7:0] ctrl_r;
   logic [3:0] stop2_r;
   logic [2:0] stop1_r;

   // Shadow copies rebuilt from bus writes, since the registers are hidden.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_r <= SWMS_RST_CTRL;
         stop2_r <= SWMS_RST_STOP2;
         stop1_r <= SWMS_RST_STOP1;
      end else if (wr_i) begin
         if (addr_i == SWMS_OFS_CTRL) ctrl_r <= wdata_i;
         if (addr_i == SWMS_OFS_STOP2) stop2_r <= wdata_i[3:0];
         if (addr_i == SWMS_OFS_STOP1) stop1_r <= wdata_i[2:0];
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   timer_gate_a: assert property (
      timer_a_irq_o == (timer_a_req_i && ctrl_r[SWMS_BIT_TAIE]))
      else $error("Timer A request gating is wrong.");
   direct_gate_a: assert property (
      direct_irq_o |-> ctrl_r[SWMS_BIT_DTIE])
      else $error("Direct request passed while disabled.");
   direct_set_a: assert property (
      sleep_exec_i && direct_taken_i && direct_transfer_on_o
      |=> direct_irq_o == ctrl_r[SWMS_BIT_DTIE])
      else $error("Direct transition flag was not set.");
   stop_two_a: assert property (
      run_o[3:0] == stop2_r)
      else $error("Standby gates of clock stop two are wrong.");
   stop_one_a: assert property (
      run_o[6:4] == stop1_r)
      else $error("Serial channel standby gates are wrong.");
   stop_read_a: assert property (
      rd_i && addr_i == SWMS_OFS_STOP2
      |=> rdata_o == (SWMS_HI_STOP2 | {4'h0, $past(stop2_r)}))
      else $error("Clock stop two read back wrong.");
   ext_pulse_a: assert property (
      ext_edge_o |=> !ext_edge_o)
      else $error("Interrupt pin edge pulse is too long.");
   trig_pulse_a: assert property (
      trig_edge_o |=> !trig_edge_o)
      else $error("Trigger pin edge pulse is too long.");
endmodule

bind swms_top swms_asserts swms_asserts_inst (.*);

// >>> swms_edge.sv
`timescale 1ns/1ns
// Edge detector with selectable polarity, one-cycle pulse output.
module swms_edge (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] lvl_i,
   input wire logic [7:0] rise_i,
   output logic [7:0] edge_o
);
   logic [7:0] prev_r;

   // Previous level, reset high so a pin high at release is no edge.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_r <= 8'hFF;
      end else begin
         prev_r <= lvl_i;
      end
   end

   // Rising when the select bit is set, falling otherwise.
   always_comb begin
      edge_o = (rise_i & lvl_i & ~prev_r) | (~rise_i & ~lvl_i & prev_r);
   end
endmodule

// >>> swms_pkg.sv
package swms_pkg;
   // Register offsets (byte addresses on the 8-bit register port).
   localparam logic [7:0] SWMS_OFS_CTRL = 8'hF1;
   localparam logic [7:0] SWMS_OFS_IRQF = 8'hF3;
   localparam logic [7:0] SWMS_OFS_WAKE = 8'hF9;
   localparam logic [7:0] SWMS_OFS_STOP1 = 8'hFA;
   localparam logic [7:0] SWMS_OFS_STOP2 = 8'hFB;
   localparam logic [7:0] SWMS_OFS_IEN = 8'hF4;
   localparam logic [7:0] SWMS_OFS_ISTAT = 8'hF5;
   localparam logic [7:0] SWMS_OFS_ICLR = 8'hF6;
   // Field positions in the control register.
   localparam int SWMS_BIT_NESEL = 4;
   localparam int SWMS_BIT_EDGE = 3;
   localparam int SWMS_BIT_DIRECT_TRANSFER_ON = 2;
   localparam int SWMS_BIT_TAIE = 1;
   localparam int SWMS_BIT_DTIE = 0;
   // Field position of the direct-transition flag in the flag register.
   localparam int SWMS_BIT_DTF = 5;
   // Field positions in clock stop register one.
   localparam int SWMS_BIT_SER2 = 2;
   localparam int SWMS_BIT_SER1 = 1;
   localparam int SWMS_BIT_SYNC = 0;
   // Reset values.
   localparam logic [7:0] SWMS_RST_CTRL = 8'h00;
   localparam logic [3:0] SWMS_RST_STOP2 = 4'hF;
   localparam logic [2:0] SWMS_RST_STOP1 = 3'h7;
   localparam logic [7:0] SWMS_RST_FLAGS = 8'h00;
   localparam logic [7:0] SWMS_HI_STOP2 = 8'hF0;
   // Sampling dividers.
   localparam logic [3:0] SWMS_DIV_SLOW = 4'hF;
   localparam logic [3:0] SWMS_DIV_FAST = 4'h3;
   // Event status bit positions.
   localparam int SWMS_EV_WAKE = 0;
   localparam int SWMS_EV_DT = 1;
   localparam int SWMS_EV_EXT = 2;
   localparam int SWMS_EV_TRIG = 3;

   typedef struct packed {
      logic ser2_run;
      logic ser1_run;
      logic sync_run;
      logic evc_run;
      logic wdt_run;
      logic pwm_run;
      logic lcd_run;
   } swms_run_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } swms_bus_type;
endpackage

// >>> swms_sampler.sv
`timescale 1ns/1ns
// Synchronises pins and filters them at the selected sampling rate.
module swms_sampler (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic fast_i,
   input wire logic [9:0] pins_i,
   output logic [9:0] filt_o
);
   import swms_pkg::*;
   logic [9:0] sync1_r;
   logic [9:0] sync2_r;
   logic [9:0] samp_r;
   logic [3:0] div_r;
   logic tick;

   // Two flip-flops before any logic reads a pin.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_r <= 10'h3FF;
         sync2_r <= 10'h3FF;
      end else begin
         sync1_r <= pins_i;
         sync2_r <= sync1_r;
      end
   end

   assign tick = (div_r == 4'h0);

   // Sampling divider; reloads from the selected rate.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_r <= SWMS_DIV_SLOW;
      end else if (tick) begin
         div_r <= fast_i ? SWMS_DIV_FAST : SWMS_DIV_SLOW;
      end else begin
         div_r <= div_r - 4'h1;
      end
   end

   // A level counts only after two equal samples, which rejects glitches
   // shorter than one sampling period at the cost of added latency.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         samp_r <= 10'h3FF;
         filt_o <= 10'h3FF;
      end else if (tick) begin
         samp_r <= sync2_r;
         filt_o <= (samp_r & sync2_r) | (filt_o & (samp_r | sync2_r));
      end
   end
endmodule

// >>> swms_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Wakeup pins are noise-filtered at the clock over 16, or over 4.
// - The interrupt pin four and trigger pin edges are falling or rising.
// - Timer A requests pass to the processor only while enabled.
// - Direct-transition requests pass only while their enable is 1.
// - A sleep with direct transfer on and a direct transition sets a flag.
// - Writing 0 to the direct-transition flag while it is 1 clears it.
// - A falling edge on an enabled wakeup pin sets its wakeup flag.
// - Writing 0 clears a wakeup flag, and writing 1 leaves it alone.
// - Async serial channel two is in standby while its bit is 0.
// - Async serial channel one is in standby while its bit is 0.
// - The sync serial channel is in standby while its bit is 0.
// - The event counter is in standby while stop bit 3 is 0.
module swms_top (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [7:0] wakeup_pin_n_i,
   input wire logic [7:0] wakeup_en_i,
   input wire logic ext_interrupt_pin_four_i,
   input wire logic converter_trigger_pin_i,
   input wire logic timer_a_req_i,
   input wire logic sleep_exec_i,
   input wire logic direct_taken_i,
   output logic timer_a_irq_o,
   output logic direct_irq_o,
   output logic ext_edge_o,
   output logic trig_edge_o,
   output logic direct_transfer_on_o,
   output swms_pkg::swms_run_type run_o,
   output logic irq_o
);
   import swms_pkg::*;
   swms_bus_type bus;
   logic [7:0] ctrl_r;
   logic direct_transition_req_flag_r;
   logic [7:0] wakeup_req_flag_n_r;
   logic [2:0] stop1_r;
   logic [3:0] stop2_r;
   logic [3:0] ien_r;
   logic [3:0] istat_r;
   logic [9:0] filt;
   logic [7:0] edges;
   logic [7:0] rise_sel;
   logic [7:0] wake_set;
   logic dt_set;
   logic [3:0] ev;
   logic [7:0] rd_nxt;
   logic [5:0] rd_unused;

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // Returns one when a write strobe hits the given offset.
   function automatic logic hit(input swms_bus_type b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // Pins pass the filter; the edge pair shares it for simplicity.
   swms_sampler u_samp (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .fast_i(ctrl_r[SWMS_BIT_NESEL]),
      .pins_i({converter_trigger_pin_i, ext_interrupt_pin_four_i,
               wakeup_pin_n_i}),
      .filt_o(filt)
   );

   // Wakeup pins detect falling edges only; bits 9:8 follow the select.
   assign rise_sel = {6'h00, {2{ctrl_r[SWMS_BIT_EDGE]}}};

   swms_edge u_wedge (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .lvl_i(filt[7:0]),
      .rise_i(8'h00),
      .edge_o(edges)
   );

   swms_edge u_xedge (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .lvl_i({6'h00, filt[9:8]}),
      .rise_i(rise_sel),
      .edge_o({rd_unused, trig_edge_o, ext_edge_o})
   );

   assign wake_set = edges & wakeup_en_i;
   assign dt_set = sleep_exec_i && ctrl_r[SWMS_BIT_DIRECT_TRANSFER_ON] &&
                   direct_taken_i;

   // Control register: sampling select, edge select, enables, transfer on.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_r <= SWMS_RST_CTRL;
      end else if (hit(bus, SWMS_OFS_CTRL)) begin
         ctrl_r <= bus.wdata;
      end
   end

   assign direct_transfer_on_o = ctrl_r[SWMS_BIT_DIRECT_TRANSFER_ON];

   // Direct-transition flag; a new set wins over a clear in one cycle.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         direct_transition_req_flag_r <= 1'b0;
      end else if (dt_set) begin
         direct_transition_req_flag_r <= 1'b1;
      end else if (hit(bus, SWMS_OFS_IRQF) && !bus.wdata[SWMS_BIT_DTF]) begin
         direct_transition_req_flag_r <= 1'b0;
      end
   end

   // Wakeup flags: written zeros clear, ones keep, sets win.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wakeup_req_flag_n_r <= SWMS_RST_FLAGS;
      end else if (hit(bus, SWMS_OFS_WAKE)) begin
         wakeup_req_flag_n_r <= (wakeup_req_flag_n_r & bus.wdata)
                                | wake_set;
      end else begin
         wakeup_req_flag_n_r <= wakeup_req_flag_n_r | wake_set;
      end
   end

   // Module standby controls; zero holds the module in standby.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stop1_r <= SWMS_RST_STOP1;
         stop2_r <= SWMS_RST_STOP2;
      end else begin
         if (hit(bus, SWMS_OFS_STOP1)) begin
            stop1_r <= bus.wdata[2:0];
         end
         if (hit(bus, SWMS_OFS_STOP2)) begin
            stop2_r <= bus.wdata[3:0];
         end
      end
   end

   assign run_o.ser2_run = stop1_r[SWMS_BIT_SER2];
   assign run_o.ser1_run = stop1_r[SWMS_BIT_SER1];
   assign run_o.sync_run = stop1_r[SWMS_BIT_SYNC];
   assign run_o.evc_run = stop2_r[3];
   assign run_o.wdt_run = stop2_r[2];
   assign run_o.pwm_run = stop2_r[1];
   assign run_o.lcd_run = stop2_r[0];

   // Interrupt gating toward the processor.
   assign timer_a_irq_o = timer_a_req_i && ctrl_r[SWMS_BIT_TAIE];
   assign direct_irq_o = direct_transition_req_flag_r &&
                         ctrl_r[SWMS_BIT_DTIE];

   // Sticky event status with write-one-to-clear; set beats clear.
   assign ev = {trig_edge_o, ext_edge_o, dt_set, |wake_set};

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         istat_r <= 4'h0;
      end else if (hit(bus, SWMS_OFS_ICLR)) begin
         istat_r <= (istat_r & ~bus.wdata[3:0]) | ev;
      end else begin
         istat_r <= istat_r | ev;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ien_r <= 4'h0;
      end else if (hit(bus, SWMS_OFS_IEN)) begin
         ien_r <= bus.wdata[3:0];
      end
   end

   assign irq_o = |(istat_r & ien_r);

   // Read decode; unmapped and write-only offsets read zero.
   always_comb begin
      case (bus.addr)
         SWMS_OFS_CTRL: rd_nxt = ctrl_r;
         SWMS_OFS_IRQF: rd_nxt = {2'h0, direct_transition_req_flag_r, 5'h00};
         SWMS_OFS_WAKE: rd_nxt = wakeup_req_flag_n_r;
         SWMS_OFS_STOP1: rd_nxt = {5'h00, stop1_r};
         SWMS_OFS_STOP2: rd_nxt = SWMS_HI_STOP2 | {4'h0, stop2_r};
         SWMS_OFS_IEN: rd_nxt = {4'h0, ien_r};
         SWMS_OFS_ISTAT: rd_nxt = {4'h0, istat_r};
         default: rd_nxt = 8'h00;
      endcase
   end

   // Read data stand one cycle after the strobe and only then.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else if (bus.rd) begin
         rdata_o <= rd_nxt;
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule

// >>> tb_swms_top.sv
`timescale 1ns/1ns
module tb_swms_top;
   import swms_pkg::*;
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
   logic [7:0] wakeup_pin_n_i = 8'hFF, wakeup_en_i = 8'h7F;
   logic ext_interrupt_pin_four_i = 1'b1, converter_trigger_pin_i = 1'b1;
   logic timer_a_req_i = 1'b0, sleep_exec_i = 1'b0, direct_taken_i = 1'b0;
   logic timer_a_irq_o, direct_irq_o, ext_edge_o, trig_edge_o, irq_o;
   logic direct_transfer_on_o, rd_d = 1'b0;
   swms_run_type run_o;
   logic [7:0] exp_q[$];
   int n_errors = 0, checked = 0, n_ext = 0, n_trig = 0;

   swms_top swms_top_inst (.*);

   // System clock, 20 ns period.
   initial forever #10 clk_sys_i = ~clk_sys_i;

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      // One more edge, so callers look at the effect after it has landed.
      @(posedge clk_sys_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe, so look there.
   always @(posedge clk_sys_i) begin
      rd_d <= rd_i;
   end

   // Mid-cycle sampling keeps the monitor clear of edge races.
   always @(negedge clk_sys_i) begin
      if (rd_d) chk(rdata_o, exp_q.pop_front());
      if (ext_edge_o) n_ext++;
      if (trig_edge_o) n_trig++;
   end

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      v = 8'($urandom(32'h01aa5b33));
      cyc(8);
      nrst_i <= 1'b1;
      rd(SWMS_OFS_STOP2, 8'hFF);
      rd(SWMS_OFS_WAKE, 8'h00);
      rd(8'h80, 8'h00);
      chk({1'b0, run_o}, 8'h7F);
      // Random standby patterns, read back and seen on the gates.
      repeat (4) begin
         v = 8'($urandom);
         wr(SWMS_OFS_STOP2, v);
         wr(SWMS_OFS_STOP1, v);
         rd(SWMS_OFS_STOP2, {4'hF, v[3:0]});
         rd(SWMS_OFS_STOP1, {5'h00, v[2:0]});
         chk({1'b0, run_o}, {1'b0, v[2:0], v[3:0]});
      end
      timer_a_req_i <= 1'b1;
      wr(SWMS_OFS_CTRL, 8'h00);
      chk({7'h0, timer_a_irq_o}, 8'h00);
      wr(SWMS_OFS_CTRL, 8'h02);
      chk({7'h0, timer_a_irq_o}, 8'h01);
      // Slow sampling must not yet accept the falling pin after 12 cycles.
      wakeup_pin_n_i <= 8'hFE;
      cyc(10);
      rd(SWMS_OFS_WAKE, 8'h00);
      cyc(40);
      rd(SWMS_OFS_WAKE, 8'h01);
      wr(SWMS_OFS_CTRL, 8'h12);
      // The divider may finish a slow count first, so let it settle.
      cyc(20);
      wakeup_pin_n_i <= 8'h00;
      cyc(14);
      rd(SWMS_OFS_WAKE, 8'h7F);
      wr(SWMS_OFS_WAKE, 8'hFE);
      rd(SWMS_OFS_WAKE, 8'h7E);
      wr(SWMS_OFS_WAKE, 8'hFF);
      rd(SWMS_OFS_WAKE, 8'h7E);
      wr(SWMS_OFS_IEN, 8'h00);
      chk({7'h0, irq_o}, 8'h00);
      wr(SWMS_OFS_IEN, 8'h01);
      chk({7'h0, irq_o}, 8'h01);
      wr(SWMS_OFS_ICLR, 8'h01);
      chk({7'h0, irq_o}, 8'h00);
      // Direct transition with its enable off first, then on.
      wr(SWMS_OFS_CTRL, 8'h14);
      chk({7'h0, direct_transfer_on_o}, 8'h01);
      sleep_exec_i <= 1'b1;
      direct_taken_i <= 1'b1;
      @(posedge clk_sys_i);
      sleep_exec_i <= 1'b0;
      direct_taken_i <= 1'b0;
      rd(SWMS_OFS_IRQF, 8'h20);
      rd(SWMS_OFS_ISTAT, 8'h02);
      chk({7'h0, direct_irq_o}, 8'h00);
      wr(SWMS_OFS_IRQF, 8'hFF);
      wr(SWMS_OFS_CTRL, 8'h15);
      rd(SWMS_OFS_CTRL, 8'h15);
      chk({7'h0, direct_irq_o}, 8'h01);
      wr(SWMS_OFS_IRQF, 8'h00);
      rd(SWMS_OFS_IRQF, 8'h00);
      // Falling edges counted, then rising only after the select flips.
      for (int i = 0; i < 3; i++) begin
         if (i == 1) wr(SWMS_OFS_CTRL, 8'h1D);
         ext_interrupt_pin_four_i <= (i == 1);
         converter_trigger_pin_i <= (i == 1);
         cyc(20);
         chk({n_ext[3:0], n_trig[3:0]}, (i == 0) ? 8'h11 : 8'h22);
      end
      cyc(2);
      report_and_stop();
   end
endmodule
